/* File: rtl/blk_clk_defs.svh */
// constants of the block clock gating control: offsets, fields, resets, counts
// assumes inclusion by bare name from the package and the design modules
`ifndef BLK_CLK_DEFS_SVH
`define BLK_CLK_DEFS_SVH

`define OFS_CLOCK_CONTROL     12'h000
`define OFS_SLOW_CLOCK_CTRL   12'h004
`define OFS_CLOCK_STATUS      12'h008

`define POS_TX_CLOCK_SELECT   4
`define POS_FORCE_ACCUM       6
`define POS_CONVERTER_EN      10
`define POS_ACCUM_MEM_FORCE   15
`define POS_IO_PORT_CLK_EN    16
`define POS_IO_PORT_RESET_N   17
`define POS_DEBOUNCE_CLK_EN   18
`define POS_DEBOUNCE_RESET_N  19
`define POS_SLOW_DIV_EN       23
`define POS_SLOW_DIV_VALUE    26

`define RST_CLOCK_CONTROL     32'h0000_0000
`define RST_SLOW_DIV_VALUE    6'h20

`define IO_LINES              9
`define TX_GAP_CYCLES         3'h2
`define WAKE_CONV_CYCLES      5'h10

`endif

/* File: rtl/blk_clk_pkg.sv */
// types of the block clock gating control
// assumes blk_clk_defs.svh on the include path
package blk_clk_pkg;
  `include "blk_clk_defs.svh"

  typedef enum logic [1:0] {
    TX_SEL_AUTO  = 2'h0,
    TX_SEL_XTAL  = 2'h1,
    TX_SEL_PLL   = 2'h2,
    TX_SEL_OFF   = 2'h3
  } tx_sel_t;

  typedef enum logic [1:0] {
    TX_OFF  = 2'h0,
    TX_GAP  = 2'h1,
    TX_XTAL = 2'h3,
    TX_PLL  = 2'h2
  } tx_state_t;

  typedef struct packed {
    logic    slow_clock_divider_enable;
    logic    debounce_reset_n;
    logic    debounce_clock_enable;
    logic    io_port_reset_n;
    logic    io_port_clock_enable;
    logic    accum_memory_clock_force;
    logic    converter_clock_enable;
    logic    force_accum_clock;
    tx_sel_t tx_clock_select;
  } block_clock_control_t;

  typedef struct packed {
    logic [`IO_LINES-1:0] level;
    logic                 tick;
  } debounce_in_t;
endpackage

/* File: rtl/io_debounce.sv */
// de-bounce filter for the io port input lines
// assumes lines already synchronised and a one-cycle tick of the slow clock
`timescale 1ns/1ps
`include "blk_clk_defs.svh"
module io_debounce
  import blk_clk_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 filt_rst_n_i,
  input  wire debounce_in_t         din_i,
  output logic [`IO_LINES-1:0]      dout_o
);

  logic [`IO_LINES-1:0] last;

  genvar g;
  generate
    for (g = 0; g < `IO_LINES; g++) begin : g_line
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          last[g]   <= 1'b0;
          dout_o[g] <= 1'b0;
        end else if (!filt_rst_n_i) begin
          last[g]   <= 1'b0;
          dout_o[g] <= 1'b0;
        end else if (din_i.tick) begin
          last[g] <= din_i.level[g];
          if (last[g] == din_i.level[g]) begin
            dout_o[g] <= din_i.level[g];
          end
        end
      end
    end
  endgenerate

endmodule // io_debounce

/* File: rtl/block_clock_gating_control.sv */
// block clock gating control: transmit clock source, accumulator, converter,
// io port and de-bounce clock enables, slow clock divider, apb register slave
// assumes enables drive glitch-free gating cells; io inputs are asynchronous
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "blk_clk_defs.svh"
module block_clock_gating_control
  import blk_clk_pkg::*;
(
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 PSEL_I,
  input  wire logic                 PENABLE_I,
  input  wire logic                 PWRITE_I,
  input  wire logic [11:0]          PADDR_I,
  input  wire logic [31:0]          PWDATA_I,
  output logic [31:0]               PRDATA_O,
  output logic                      PREADY_O,
  output logic                      PSLVERR_O,
  input  wire logic                 TX_REQ_I,
  input  wire logic                 RX_ACTIVE_I,
  input  wire logic                 WAKE_EVENT_I,
  input  wire logic                 WAKE_SAMPLE_CFG_I,
  input  wire logic [`IO_LINES-1:0] IO_LINE_I,
  output logic                      TX_CLK_XTAL_EN_O,
  output logic                      TX_CLK_PLL_EN_O,
  output logic                      ACCUM_CLK_EN_O,
  output logic                      ACCUM_MEM_CLK_EN_O,
  output logic                      CONV_CLK_EN_O,
  output logic                      IO_PORT_CLK_EN_O,
  output logic                      IO_PORT_RST_N_O,
  output logic                      SLOW_TICK_O,
  output logic                      LED_BLINK_O,
  output logic [`IO_LINES-1:0]      IO_DEBOUNCED_O
);

  // ---------------- register bus ----------------
  block_clock_control_t ctrl;
  logic [5:0]           div_value;
  tx_state_t            tx_state;
  tx_state_t            tx_target;
  logic [2:0]           gap_cnt;
  logic [5:0]           div_cnt;
  logic                 slow_tick;
  logic [4:0]           wake_cnt;
  logic                 wake_s1;
  logic                 wake_s2;
  logic                 wake_s3;
  logic                 wcfg_s1;
  logic                 wcfg_s2;
  logic [`IO_LINES-1:0] io_s1;
  logic [`IO_LINES-1:0] io_s2;
  logic [`IO_LINES-1:0] deb_out;

  wire setup_phase = PSEL_I & ~PENABLE_I;
  wire access_done = PSEL_I & PENABLE_I & PREADY_O;
  wire sel_ctrl    = (PADDR_I == `OFS_CLOCK_CONTROL);
  wire sel_slow    = (PADDR_I == `OFS_SLOW_CLOCK_CTRL);
  wire sel_stat    = (PADDR_I == `OFS_CLOCK_STATUS);
  wire addr_ok     = sel_ctrl | sel_slow | sel_stat;
  wire wr_ctrl     = access_done & PWRITE_I & sel_ctrl;
  wire wr_slow     = access_done & PWRITE_I & sel_slow;

  wire [31:0] ctrl_word =
    ({31'h0, ctrl.slow_clock_divider_enable} << `POS_SLOW_DIV_EN) |
    ({31'h0, ctrl.debounce_reset_n}          << `POS_DEBOUNCE_RESET_N) |
    ({31'h0, ctrl.debounce_clock_enable}     << `POS_DEBOUNCE_CLK_EN) |
    ({31'h0, ctrl.io_port_reset_n}           << `POS_IO_PORT_RESET_N) |
    ({31'h0, ctrl.io_port_clock_enable}      << `POS_IO_PORT_CLK_EN) |
    ({31'h0, ctrl.accum_memory_clock_force}  << `POS_ACCUM_MEM_FORCE) |
    ({31'h0, ctrl.converter_clock_enable}    << `POS_CONVERTER_EN) |
    ({31'h0, ctrl.force_accum_clock}         << `POS_FORCE_ACCUM) |
    ({30'h0, ctrl.tx_clock_select}           << `POS_TX_CLOCK_SELECT);

  wire [31:0] slow_word = {div_value, 26'h0};
  wire [31:0] stat_word = {15'h0, IO_DEBOUNCED_O, LED_BLINK_O, CONV_CLK_EN_O,
                           ACCUM_MEM_CLK_EN_O, ACCUM_CLK_EN_O,
                           TX_CLK_PLL_EN_O, TX_CLK_XTAL_EN_O, tx_state};

  wire [31:0] read_word = sel_ctrl ? ctrl_word :
                          sel_slow ? slow_word :
                          sel_stat ? stat_word : 32'h0;

  wire [31:0] wd = PWDATA_I;
  block_clock_control_t wr_val;
  assign wr_val.slow_clock_divider_enable = wd[`POS_SLOW_DIV_EN];
  assign wr_val.debounce_reset_n          = wd[`POS_DEBOUNCE_RESET_N];
  assign wr_val.debounce_clock_enable     = wd[`POS_DEBOUNCE_CLK_EN];
  assign wr_val.io_port_reset_n           = wd[`POS_IO_PORT_RESET_N];
  assign wr_val.io_port_clock_enable      = wd[`POS_IO_PORT_CLK_EN];
  assign wr_val.accum_memory_clock_force  = wd[`POS_ACCUM_MEM_FORCE];
  assign wr_val.converter_clock_enable    = wd[`POS_CONVERTER_EN];
  assign wr_val.force_accum_clock         = wd[`POS_FORCE_ACCUM];
  assign wr_val.tx_clock_select           =
    tx_sel_t'(wd[`POS_TX_CLOCK_SELECT +: 2]);

  // no wait state: ready raised during the access phase
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
    end else begin
      PREADY_O  <= setup_phase;
      PSLVERR_O <= setup_phase & ~addr_ok;
      PRDATA_O  <= setup_phase ? read_word : 32'h0;
    end
  end

  // reset value of the control fields, picked out of the reset word
  localparam logic [31:0] rst_word = `RST_CLOCK_CONTROL;
  localparam block_clock_control_t rst_ctrl = '{
    slow_clock_divider_enable: rst_word[`POS_SLOW_DIV_EN],
    debounce_reset_n:          rst_word[`POS_DEBOUNCE_RESET_N],
    debounce_clock_enable:     rst_word[`POS_DEBOUNCE_CLK_EN],
    io_port_reset_n:           rst_word[`POS_IO_PORT_RESET_N],
    io_port_clock_enable:      rst_word[`POS_IO_PORT_CLK_EN],
    accum_memory_clock_force:  rst_word[`POS_ACCUM_MEM_FORCE],
    converter_clock_enable:    rst_word[`POS_CONVERTER_EN],
    force_accum_clock:         rst_word[`POS_FORCE_ACCUM],
    tx_clock_select:           tx_sel_t'(rst_word[`POS_TX_CLOCK_SELECT +: 2])
  };

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= rst_ctrl;
    end else if (wr_ctrl) begin
      ctrl <= wr_val;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_value <= `RST_SLOW_DIV_VALUE;
    end else if (wr_slow) begin
      div_value <= PWDATA_I[`POS_SLOW_DIV_VALUE +: 6];
    end
  end

  // ---------------- input synchronisers ----------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      wcfg_s1 <= 1'b0;
      wcfg_s2 <= 1'b0;
      io_s1   <= '0;
      io_s2   <= '0;
    end else begin
      wake_s1 <= WAKE_EVENT_I;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      wcfg_s1 <= WAKE_SAMPLE_CFG_I;
      wcfg_s2 <= wcfg_s1;
      io_s1   <= IO_LINE_I;
      io_s2   <= io_s1;
    end
  end

  // ---------------- transmit clock source ----------------
  always_comb begin
    case (ctrl.tx_clock_select)
      TX_SEL_AUTO: tx_target = TX_REQ_I ? TX_PLL : TX_OFF;
      TX_SEL_XTAL: tx_target = TX_XTAL;
      TX_SEL_PLL:  tx_target = TX_PLL;
      TX_SEL_OFF:  tx_target = TX_OFF;
      default:     tx_target = TX_OFF;
    endcase
  end

  // break before make: every change of source drops both enables first
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_state <= TX_OFF;
      gap_cnt  <= 3'h0;
    end else begin
      case (tx_state)
        TX_OFF, TX_XTAL, TX_PLL: begin
          if (tx_target != tx_state) begin
            tx_state <= TX_GAP;
            gap_cnt  <= 3'h0;
          end
        end
        TX_GAP: begin
          if (gap_cnt == `TX_GAP_CYCLES) begin
            tx_state <= tx_target;
          end else begin
            gap_cnt <= gap_cnt + 3'h1;
          end
        end
        default: tx_state <= TX_OFF;
      endcase
    end
  end

  // ---------------- slow clock divider ----------------
  wire [5:0] div_limit = (div_value == 6'h0) ? 6'h0 : div_value - 6'h1;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_cnt   <= 6'h0;
      slow_tick <= 1'b0;
    end else if (!ctrl.slow_clock_divider_enable) begin
      div_cnt   <= 6'h0;
      slow_tick <= 1'b0;
    end else if (div_cnt >= div_limit) begin
      div_cnt   <= 6'h0;
      slow_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 6'h1;
      slow_tick <= 1'b0;
    end
  end

  wire deb_tick = slow_tick & ctrl.debounce_clock_enable;

  // ---------------- wake converter window ----------------
  wire wake_rise = wake_s2 & ~wake_s3;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_cnt <= 5'h0;
    end else if (wake_rise & wcfg_s2) begin
      wake_cnt <= `WAKE_CONV_CYCLES;
    end else if (wake_cnt != 5'h0) begin
      wake_cnt <= wake_cnt - 5'h1;
    end
  end

  // ---------------- enable outputs ----------------
  wire next_tx_xtal_en = (tx_state == TX_XTAL);
  wire next_tx_pll_en  = (tx_state == TX_PLL);
  wire next_accum_en   = ctrl.force_accum_clock | RX_ACTIVE_I;
  wire next_accmem_en  = ctrl.accum_memory_clock_force | RX_ACTIVE_I;
  wire next_conv_en    = ctrl.converter_clock_enable | (wake_cnt != 5'h0);
  wire next_led        = !ctrl.debounce_reset_n ? 1'b0 :
                         (LED_BLINK_O ^ deb_tick);

  // transmit source enables, registered so gating cells see clean levels
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TX_CLK_XTAL_EN_O <= 1'b0;
      TX_CLK_PLL_EN_O  <= 1'b0;
    end else begin
      TX_CLK_XTAL_EN_O <= next_tx_xtal_en;
      TX_CLK_PLL_EN_O  <= next_tx_pll_en;
    end
  end

  // receive side and converter enables
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACCUM_CLK_EN_O     <= 1'b0;
      ACCUM_MEM_CLK_EN_O <= 1'b0;
      CONV_CLK_EN_O      <= 1'b0;
    end else begin
      ACCUM_CLK_EN_O     <= next_accum_en;
      ACCUM_MEM_CLK_EN_O <= next_accmem_en;
      CONV_CLK_EN_O      <= next_conv_en;
    end
  end

  // io port controls, slow tick, led and de-bounced lines
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IO_PORT_CLK_EN_O <= 1'b0;
      IO_PORT_RST_N_O  <= 1'b0;
      SLOW_TICK_O      <= 1'b0;
      LED_BLINK_O      <= 1'b0;
      IO_DEBOUNCED_O   <= '0;
    end else begin
      IO_PORT_CLK_EN_O <= ctrl.io_port_clock_enable;
      IO_PORT_RST_N_O  <= ctrl.io_port_reset_n;
      SLOW_TICK_O      <= slow_tick;
      LED_BLINK_O      <= next_led;
      IO_DEBOUNCED_O   <= deb_out;
    end
  end

  // ---------------- de-bounce filter ----------------
  debounce_in_t deb_in;
  assign deb_in.level = io_s2 & {`IO_LINES{ctrl.io_port_clock_enable}};
  assign deb_in.tick  = deb_tick;

  io_debounce u_debounce (
    .clk_i        (SYS_CLK_I),
    .rst_n_i      (RST_N_I),
    .filt_rst_n_i (ctrl.debounce_reset_n),
    .din_i        (deb_in),
    .dout_o       (deb_out)
  );

endmodule // block_clock_gating_control

/* File: verification/block_clock_gating_control_properties.sv */
// port checks of the block clock gating control
// assumes bound to the top module; control word shadowed from apb writes
`timescale 1ns/1ps
`include "blk_clk_defs.svh"
module blk_clk_checker
  import blk_clk_pkg::*;
(
  input wire logic                 SYS_CLK_I,
  input wire logic                 RST_N_I,
  input wire logic                 PSEL_I,
  input wire logic                 PENABLE_I,
  input wire logic                 PWRITE_I,
  input wire logic [11:0]          PADDR_I,
  input wire logic [31:0]          PWDATA_I,
  input wire logic                 PREADY_O,
  input wire logic                 TX_REQ_I,
  input wire logic                 RX_ACTIVE_I,
  input wire logic                 TX_CLK_XTAL_EN_O,
  input wire logic                 TX_CLK_PLL_EN_O,
  input wire logic                 ACCUM_CLK_EN_O,
  input wire logic                 ACCUM_MEM_CLK_EN_O,
  input wire logic                 CONV_CLK_EN_O,
  input wire logic                 IO_PORT_CLK_EN_O,
  input wire logic                 IO_PORT_RST_N_O,
  input wire logic                 SLOW_TICK_O,
  input wire logic                 LED_BLINK_O
);
  logic [31:0] ctl;
  wire         ctl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
                        && (PADDR_I == `OFS_CLOCK_CONTROL);
  wire  [1:0]  sel    = ctl[5:4];

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) ctl <= 32'h0;
    else if (ctl_wr) ctl <= PWDATA_I;
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_tx_auto_idle: assert property ((sel == 2'h0 && !TX_REQ_I)[*4]
    |-> !TX_CLK_XTAL_EN_O && !TX_CLK_PLL_EN_O) else $error("tx clock on while idle");
  a_tx_auto_busy: assert property ((sel == 2'h0 && TX_REQ_I)[*8]
    |-> TX_CLK_PLL_EN_O && !TX_CLK_XTAL_EN_O) else $error("tx pll clock missing");
  a_tx_xtal_force: assert property ((sel == 2'h1)[*8]
    |-> TX_CLK_XTAL_EN_O && !TX_CLK_PLL_EN_O) else $error("tx crystal clock missing");
  a_tx_pll_force: assert property ((sel == 2'h2)[*8]
    |-> TX_CLK_PLL_EN_O && !TX_CLK_XTAL_EN_O) else $error("tx pll force missing");
  a_tx_forced_off: assert property ((sel == 2'h3)[*4]
    |-> !TX_CLK_XTAL_EN_O && !TX_CLK_PLL_EN_O) else $error("tx clock not off");
  a_tx_never_both: assert property (!(TX_CLK_XTAL_EN_O && TX_CLK_PLL_EN_O))
    else $error("both tx sources on");
  a_tx_switch_gap: assert property ($fell(TX_CLK_XTAL_EN_O) |-> (!TX_CLK_PLL_EN_O)[*3])
    else $error("no gap on tx switch");
  a_accum_follow: assert property (ACCUM_CLK_EN_O == ($past(ctl[6]) || $past(RX_ACTIVE_I)))
    else $error("accumulator enable wrong");
  a_accmem_follow: assert property (ACCUM_MEM_CLK_EN_O == ($past(ctl[15]) || $past(RX_ACTIVE_I)))
    else $error("accumulator memory enable wrong");
  a_conv_forced_on: assert property ($past(ctl[10]) |-> CONV_CLK_EN_O)
    else $error("converter clock not on");
  a_io_port_clock: assert property (IO_PORT_CLK_EN_O == $past(ctl[16]))
    else $error("io port clock enable wrong");
  a_io_port_reset: assert property (IO_PORT_RST_N_O == $past(ctl[17]))
    else $error("io port reset wrong");
  a_led_held_reset: assert property (!$past(ctl[19]) && !$past(ctl[19], 2) |-> !LED_BLINK_O)
    else $error("led not held in reset");
  a_slow_tick_off: assert property (!$past(ctl[23]) && !$past(ctl[23], 2) |-> !SLOW_TICK_O)
    else $error("slow tick while divider off");
endmodule // blk_clk_checker

bind block_clock_gating_control blk_clk_checker chk_u (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .TX_REQ_I(TX_REQ_I), .RX_ACTIVE_I(RX_ACTIVE_I), .TX_CLK_XTAL_EN_O(TX_CLK_XTAL_EN_O),
  .TX_CLK_PLL_EN_O(TX_CLK_PLL_EN_O), .ACCUM_CLK_EN_O(ACCUM_CLK_EN_O),
  .ACCUM_MEM_CLK_EN_O(ACCUM_MEM_CLK_EN_O), .CONV_CLK_EN_O(CONV_CLK_EN_O),
  .IO_PORT_CLK_EN_O(IO_PORT_CLK_EN_O), .IO_PORT_RST_N_O(IO_PORT_RST_N_O),
  .SLOW_TICK_O(SLOW_TICK_O), .LED_BLINK_O(LED_BLINK_O));

/* File: verification/tb.sv */
// self-checking bench of the block clock gating control
// assumes the package and the bound checker compiled before it
`timescale 1ns/1ps
`include "blk_clk_defs.svh"
module tb
  import blk_clk_pkg::*;
;
  localparam logic [31:0] FIELDS = 32'h008f_8470;
  logic        sys_clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, tx_req, rx_active, wake_ev, wake_cfg, led_last;
  logic [11:0] paddr;
  logic [31:0] pwdata, v;
  logic [8:0]  io_line;
  logic        moved;
  wire  [31:0] prdata;
  wire         pready, pslverr, xtal_en, pll_en, acc_en, accm_en, conv_en;
  wire         io_clk_en, io_rst_n, slow_tick, led;
  wire  [8:0]  io_deb;
  logic [32:0] expq [$];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          toggles, ticks;
  integer      seed = 32'h9edc86d7;

  block_clock_gating_control dut_u (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TX_REQ_I(tx_req), .RX_ACTIVE_I(rx_active),
    .WAKE_EVENT_I(wake_ev), .WAKE_SAMPLE_CFG_I(wake_cfg), .IO_LINE_I(io_line),
    .TX_CLK_XTAL_EN_O(xtal_en), .TX_CLK_PLL_EN_O(pll_en), .ACCUM_CLK_EN_O(acc_en),
    .ACCUM_MEM_CLK_EN_O(accm_en), .CONV_CLK_EN_O(conv_en), .IO_PORT_CLK_EN_O(io_clk_en),
    .IO_PORT_RST_N_O(io_rst_n), .SLOW_TICK_O(slow_tick), .LED_BLINK_O(led),
    .IO_DEBOUNCED_O(io_deb));

  always #25 sys_clk = ~sys_clk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard, well above the length of the sequence
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // read results come back in request order
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      check({pslverr, prdata}, expq.size() ? expq.pop_front() : 33'h1_dead_beef);
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic watch(input int n);
    moved = 1'b0;
    toggles = 0;
    ticks = 0;
    @(posedge sys_clk);
    led_last = led;
    repeat (n) begin
      @(posedge sys_clk);
      if (io_deb !== 9'h155) moved = 1'b1;
      if (led !== led_last) toggles++;
      if (slow_tick === 1'b1) ticks++;
      led_last = led;
    end
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, tx_req, rx_active, wake_ev, wake_cfg, led_last} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    io_line = 9'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({xtal_en, pll_en, acc_en, accm_en, conv_en, io_clk_en, io_rst_n, led, io_deb}, 0);
    rd(`OFS_CLOCK_CONTROL, {1'b0, `RST_CLOCK_CONTROL});
    rd(`OFS_SLOW_CLOCK_CTRL, {1'b0, `RST_SLOW_DIV_VALUE, 26'h0});
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    rd(12'h00c, {1'b1, 32'h0});
    rd(`OFS_CLOCK_CONTROL, 33'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed) & FIELDS;
      rx_active <= 1'($random(seed));
      apb(1'b1, `OFS_CLOCK_CONTROL, v);
      repeat (2) @(posedge sys_clk);
      check({acc_en, accm_en}, {v[6] | rx_active, v[15] | rx_active});
      check(conv_en, v[10]);
      check({io_clk_en, io_rst_n}, {v[16], v[17]});
      rd(`OFS_CLOCK_CONTROL, {1'b0, v});
    end
    rx_active <= 1'b0;
    $display("test fields done");
    for (int i = 0; i < 8; i++) begin
      tx_req <= i[0];
      apb(1'b1, `OFS_CLOCK_CONTROL, {26'h0, i[2:1], 4'h0});
      repeat (8) @(posedge sys_clk);
      check({xtal_en, pll_en}, {i[2:1] == 2'h1, i[2:1] == 2'h2 || i[2:0] == 3'h1});
    end
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h0000_0010);
    repeat (8) @(posedge sys_clk);
    rd(`OFS_CLOCK_STATUS, {1'b0, 29'h0, 1'b1, TX_XTAL});
    $display("test tx select done");
    apb(1'b1, `OFS_SLOW_CLOCK_CTRL, {6'h2, 26'h0});
    io_line <= 9'h155;
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h008f_0000);
    repeat (30) @(posedge sys_clk);
    check(io_deb, 9'h155);
    io_line <= 9'h0aa;
    @(posedge sys_clk);
    io_line <= 9'h155;
    watch(40);
    check(moved, 1'b0);
    check(toggles, 20);
    check(ticks, 20);
    io_line <= 9'h0aa;
    repeat (12) @(posedge sys_clk);
    check(io_deb, 9'h0aa);
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h008b_0000);
    watch(20);
    check(toggles, 0);
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h008c_0000);
    repeat (12) @(posedge sys_clk);
    check(io_deb, 9'h0);
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h008f_0000);
    repeat (12) @(posedge sys_clk);
    check(io_deb, 9'h0aa);
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h0087_0000);
    repeat (12) @(posedge sys_clk);
    check({led, io_deb}, 10'h0);
    $display("test debounce done");
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h0);
    wake_cfg <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wake_ev <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(conv_en, 1'b1);
    wake_ev <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check(conv_en, 1'b0);
    wake_cfg <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wake_ev <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(conv_en, 1'b0);
    wake_ev <= 1'b0;
    $display("test wake done");
    apb(1'b1, `OFS_CLOCK_CONTROL, 32'h0003_8040);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({acc_en, accm_en, io_clk_en, io_rst_n}, 4'h0);
    rst_n <= 1'b1;
    rd(`OFS_CLOCK_CONTROL, 33'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule // tb
